// file: pkg/fpec_pkg.sv
`default_nettype none
package fpec_pkg;
  // Lock and key codes
  localparam logic [7:0]  KEY_FIRST_CODE  = 8'ha5;
  localparam logic [7:0]  KEY_SECOND_CODE = 8'hf1;
  // Memory layout
  localparam int          MEM_AW          = 13;
  localparam int          MEM_BYTES       = 8192;
  localparam int          PAGE_AW         = 9;
  localparam int          PAGE_BYTES      = 512;
  localparam logic [15:0] USER_LIMIT      = 16'h1dff;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  // Control register fields
  localparam int          CTL_WE_BIT      = 0;
  localparam int          CTL_EE_BIT      = 1;
  localparam logic [7:0]  CTL_MASK        = 8'h03;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  // Timing
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          WRITE_TIME_NS   = 40000;
  localparam int          ERASE_TIME_NS   = 10000000;
  localparam int          WRITE_CYCLES    = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W           = 24;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_FIRST, KEY_ARMED, KEY_BLOCKED} fpec_key_type;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} fpec_op_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } fpec_xwr_type;

  typedef struct packed {
    logic             blank_meta;
    logic             blank;
    fpec_key_type     key;
    fpec_op_type      op;
    logic [CNT_W-1:0] count;
    logic [15:0]      addr;
    logic [7:0]       ctl;
    logic             external_data_ram_wr;
    fpec_xwr_type     external_data_ram;
    logic [7:0]       cread_data;
    logic             err_pulse;
    logic             err_pend;
    logic             err_flag;
  } fpec_state_type;
endpackage
`default_nettype wire

// file: rtl/fpec_top.sv
`timescale 1ns/1ps
`default_nettype none
module fpec_top #(
  parameter int ERASE_CYCLES_P = fpec_pkg::ERASE_CYCLES
) (
  // Clock, reset and blank status
  input  wire logic                   I_SYS_CLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_SYS_RESET,
  input  wire logic                   I_DEVICE_BLANK,
  // Core control and key writes
  input  wire logic                   I_CTL_WR,
  input  wire logic [7:0]             I_CTL_DATA,
  input  wire logic                   I_KEY_WR,
  input  wire logic [7:0]             I_KEY_DATA,
  // Core external data writes
  input  wire logic                   I_XWR_VALID,
  input  wire fpec_pkg::fpec_xwr_type I_XWR,
  // Code memory read
  input  wire logic                   I_CREAD_VALID,
  input  wire logic [15:0]            I_CREAD_ADDR,
  // Debug port
  input  wire logic                   I_DBG_WR,
  input  wire logic                   I_DBG_ERASE,
  input  wire fpec_pkg::fpec_xwr_type I_DBG,
  // Status
  output logic                        O_STALL,
  output logic [7:0]                  O_CTL,
  output logic                        O_KEY_ARMED,
  output logic                        O_KEY_BLOCKED,
  output logic                        O_FLASH_ERROR_RESET,
  output logic                        O_FLASH_ERROR_FLAG,
  // Data RAM write path and code read data
  output logic                        O_EXTERNAL_DATA_RAM_WR,
  output fpec_pkg::fpec_xwr_type      O_EXTERNAL_DATA_RAM,
  output logic [7:0]                  O_CREAD_DATA
);
  import fpec_pkg::*;

  logic [1:0]        rst_sync;
  logic              rst_n;
  fpec_state_type    st;
  fpec_state_type    next_st;
  logic [7:0]        mem [MEM_BYTES];
  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0]        mem_wdata;
  logic [CNT_W-1:0]  target;
  logic              xwr_flash;

  function automatic logic in_user(input logic [15:0] a);
    return a <= USER_LIMIT;
  endfunction

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign target    = (st.op == OP_ERASE) ? CNT_W'(ERASE_CYCLES_P - 1) : CNT_W'(WRITE_CYCLES - 1);
  assign xwr_flash = I_XWR_VALID && st.op == OP_IDLE && st.ctl[CTL_WE_BIT];

  always_comb begin
    next_st           = st;
    next_st.err_pulse = 1'b0;
    next_st.external_data_ram_wr   = 1'b0;
    next_st.blank_meta = I_DEVICE_BLANK;
    next_st.blank     = st.blank_meta;
    mem_we            = 1'b0;
    mem_addr          = st.addr[MEM_AW-1:0];
    mem_wdata         = ERASED_BYTE;
    if (I_CREAD_VALID) begin
      next_st.cread_data = mem[I_CREAD_ADDR[MEM_AW-1:0]];
      if (!in_user(I_CREAD_ADDR)) begin
        next_st.err_pulse = 1'b1;
      end
    end
    if (I_CTL_WR) begin
      next_st.ctl = I_CTL_DATA & CTL_MASK;
    end
    if (I_KEY_WR) begin
      unique case (st.key)
        KEY_LOCKED:  next_st.key = (I_KEY_DATA == KEY_FIRST_CODE) ? KEY_FIRST : KEY_BLOCKED;
        KEY_FIRST:   next_st.key = (I_KEY_DATA == KEY_SECOND_CODE) ? KEY_ARMED : KEY_BLOCKED;
        KEY_ARMED:   next_st.key = KEY_BLOCKED;
        KEY_BLOCKED: next_st.key = KEY_BLOCKED;
      endcase
    end
    if (st.op != OP_IDLE) begin
      // Hardware-timed operation; an erase writes ERASED_BYTE to the page one byte per cycle
      if (st.op == OP_ERASE && st.count < CNT_W'(PAGE_BYTES)) begin
        mem_we   = 1'b1;
        mem_addr = {st.addr[MEM_AW-1:PAGE_AW], st.count[PAGE_AW-1:0]};
      end
      if (st.count == target) begin
        next_st.op = OP_IDLE;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end else if (I_XWR_VALID) begin
      if (!st.ctl[CTL_WE_BIT]) begin
        next_st.external_data_ram_wr = 1'b1;
        next_st.external_data_ram    = I_XWR;
      end else if (!in_user(I_XWR.addr)) begin
        next_st.err_pulse = 1'b1;
      end else if (st.blank) begin
        next_st.op = OP_IDLE;
      end else if (st.key == KEY_ARMED) begin
        next_st.key   = KEY_LOCKED;
        next_st.count = '0;
        next_st.addr  = I_XWR.addr;
        if (st.ctl[CTL_EE_BIT]) begin
          next_st.op = OP_ERASE;
        end else begin
          next_st.op = OP_WRITE;
          mem_we     = 1'b1;
          mem_addr   = I_XWR.addr[MEM_AW-1:0];
          mem_wdata  = mem[I_XWR.addr[MEM_AW-1:0]] & I_XWR.data;
        end
      end else begin
        next_st.key = KEY_BLOCKED;
      end
    end else if ((I_DBG_WR || I_DBG_ERASE) && in_user(I_DBG.addr)) begin
      next_st.count = '0;
      next_st.addr  = I_DBG.addr;
      if (I_DBG_ERASE) begin
        next_st.op = OP_ERASE;
      end else begin
        next_st.op = OP_WRITE;
        mem_we     = 1'b1;
        mem_addr   = I_DBG.addr[MEM_AW-1:0];
        mem_wdata  = mem[I_DBG.addr[MEM_AW-1:0]] & I_DBG.data;
      end
    end
    if (st.err_pulse) begin
      next_st.err_pend = 1'b1;
    end
    if (I_SYS_RESET) begin
      next_st.err_flag = st.err_pend || st.err_pulse;
      next_st.err_pend = 1'b0;
      next_st.key      = KEY_LOCKED;
      next_st.op       = OP_IDLE;
      next_st.ctl      = CTL_RESET;
      next_st.external_data_ram_wr  = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.key <= KEY_LOCKED;
      st.op  <= OP_IDLE;
      st.ctl <= CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  assign O_STALL             = st.op != OP_IDLE;
  assign O_CTL               = st.ctl;
  assign O_KEY_ARMED         = st.key == KEY_ARMED;
  assign O_KEY_BLOCKED       = st.key == KEY_BLOCKED;
  assign O_FLASH_ERROR_RESET = st.err_pulse;
  assign O_FLASH_ERROR_FLAG  = st.err_flag;
  assign O_EXTERNAL_DATA_RAM_WR           = st.external_data_ram_wr;
  assign O_EXTERNAL_DATA_RAM              = st.external_data_ram;
  assign O_CREAD_DATA        = st.cread_data;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!rst_n || I_SYS_RESET);

  AST_STALL_HELD: assert property (
    (xwr_flash && st.key == KEY_ARMED && in_user(I_XWR.addr) && !st.blank)
      |=> O_STALL [*8])
    else $error("Stall not held after operation start");
  AST_OP_LENGTH: assert property (
    (st.op == OP_WRITE) |=> (O_STALL == ($past(st.count) != CNT_W'(WRITE_CYCLES - 1))))
    else $error("Write stall length wrong");
  AST_ERASE_LENGTH: assert property (
    (st.op == OP_ERASE) |=> (O_STALL == ($past(st.count) != CNT_W'(ERASE_CYCLES_P - 1))))
    else $error("Erase stall length wrong");
  AST_COUNT_STEP: assert property (
    O_STALL |-> st.count == ($past(O_STALL) ? $past(st.count) + 1'b1 : CNT_W'(0)))
    else $error("Operation counter did not step");
  AST_BAD_KEY: assert property (
    (I_KEY_WR && st.key == KEY_LOCKED && I_KEY_DATA != KEY_FIRST_CODE) |=> O_KEY_BLOCKED)
    else $error("Wrong first key did not block");
  AST_ARM: assert property (
    (I_KEY_WR && st.key == KEY_FIRST && I_KEY_DATA == KEY_SECOND_CODE) |=> O_KEY_ARMED)
    else $error("Key sequence did not arm");
  AST_BLOCK_STICKY: assert property (
    O_KEY_BLOCKED |=> O_KEY_BLOCKED)
    else $error("Blocked state left without reset");
  AST_EARLY_OP: assert property (
    (xwr_flash && in_user(I_XWR.addr) && !st.blank
      && (st.key == KEY_LOCKED || st.key == KEY_FIRST)) |=> O_KEY_BLOCKED)
    else $error("Unarmed operation did not block");
  AST_RELOCK: assert property (
    ($rose(O_STALL) && O_KEY_ARMED == 1'b0) |-> ##1 !O_KEY_ARMED [*2])
    else $error("Lock stayed open after operation");
  AST_ROUTE: assert property (
    (I_XWR_VALID && !O_STALL) |=> (O_EXTERNAL_DATA_RAM_WR == !$past(st.ctl[CTL_WE_BIT])))
    else $error("Data write routed wrongly");
  AST_RANGE_ERR: assert property (
    (xwr_flash && !in_user(I_XWR.addr)) |=> O_FLASH_ERROR_RESET && !O_STALL)
    else $error("Out of range write did not request reset");
  AST_CTL_HOLD: assert property (
    !I_CTL_WR |=> $stable(O_CTL))
    else $error("Write enable changed without software");
  AST_ERASE_ONES: assert property (
    (st.op == OP_ERASE && st.count < CNT_W'(PAGE_BYTES))
      |=> mem[$past(mem_addr)] == ERASED_BYTE)
    else $error("Erase did not write all-ones");
  AST_ONLY_CLEAR: assert property (
    (mem_we && st.op == OP_IDLE) |-> (mem_wdata & ~mem[mem_addr]) == 8'h00)
    else $error("Byte write set a bit");

  COV_WRITE: cover property ($rose(O_STALL) ##1 st.op == OP_WRITE);
  COV_ERASE: cover property ($rose(O_STALL) ##1 st.op == OP_ERASE);
  COV_BLOCK: cover property ($rose(O_KEY_BLOCKED));
  COV_ERR:   cover property (O_FLASH_ERROR_RESET);
endmodule // fpec_top
`default_nettype wire

// file: sim/fpec_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpec_core_model (
  // Clock and stall
  input  wire logic              i_clk,
  input  wire logic              i_stall,
  // Control, key and data writes
  output logic                   o_ctl_wr,
  output logic                   o_key_wr,
  output logic                   o_xwr_valid,
  output fpec_pkg::fpec_xwr_type o_xwr
);
  import fpec_pkg::*;
  initial begin
    o_ctl_wr    = 1'b0;
    o_key_wr    = 1'b0;
    o_xwr_valid = 1'b0;
    o_xwr       = '0;
  end
  // One strobe per call: 0 control, 1 key, 2 data write
  task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    while (i_stall !== 1'b0) begin
      @(posedge i_clk);
      #1;
    end
    o_ctl_wr    = (k == 2'd0);
    o_key_wr    = (k == 2'd1);
    o_xwr_valid = (k == 2'd2);
    o_xwr       = '{addr: a, data: d};
    @(posedge i_clk);
    #1;
    o_ctl_wr    = 1'b0;
    o_key_wr    = 1'b0;
    o_xwr_valid = 1'b0;
    // Idle bus shows the inverse of the last value
    o_xwr       = ~o_xwr;
    @(posedge i_clk);
    #1;
  endtask
  // Key codes in order, any spacing
  task automatic unlock();
    issue(2'd1, 16'h0000, KEY_FIRST_CODE);
    issue(2'd1, 16'h0000, KEY_SECOND_CODE);
  endtask
endmodule // fpec_core_model
`default_nettype wire

// file: sim/flash_program_erase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_test;
  import fpec_pkg::*;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [15:0] raddr;
    logic [7:0]  exp;
  } fpec_row_type;
  localparam int ERASE_N = 600;
  localparam int WRITE_N = 2000;
  logic         clk = 1'b0, rst_n = 1'b0, sys_rst = 1'b0, blank = 1'b0;
  logic         cr_valid = 1'b0, dbg_wr = 1'b0, dbg_erase = 1'b0;
  logic [15:0]  cr_addr = '0;
  fpec_xwr_type dbg = '0, xwr, external_data_ram_q, external_data_ram_seen;
  logic         ctl_wr, key_wr, xwr_valid, stall, armed, blocked, err_rst, err_flag, external_data_ram_wr;
  logic [7:0]   ctl, rdata;
  int           miscompares = 0, compares = 0, external_data_ram_hits = 0, err_hits = 0;
  int           stall_cnt = 0, stall_mark = 0;
  fpec_row_type rows [6] = '{
    '{8'h03, 16'h0010, 8'h00, 16'h01ff, 8'hff},
    '{8'h01, 16'h0005, 8'h3c, 16'h0005, 8'h3c},
    '{8'h01, 16'h0005, 8'hf0, 16'h0005, 8'h30},
    '{8'h03, 16'h0100, 8'h12, 16'h0005, 8'hff},
    '{8'h03, 16'h1c00, 8'h00, 16'h1dff, 8'hff},
    '{8'h01, 16'h1dff, 8'ha5, 16'h1dff, 8'ha5}};
  fpec_top #(.ERASE_CYCLES_P(ERASE_N)) fpec_top_inst (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_SYS_RESET(sys_rst), .I_DEVICE_BLANK(blank),
    .I_CTL_WR(ctl_wr), .I_CTL_DATA(xwr.data), .I_KEY_WR(key_wr), .I_KEY_DATA(xwr.data),
    .I_XWR_VALID(xwr_valid), .I_XWR(xwr), .I_CREAD_VALID(cr_valid), .I_CREAD_ADDR(cr_addr),
    .I_DBG_WR(dbg_wr), .I_DBG_ERASE(dbg_erase), .I_DBG(dbg), .O_STALL(stall), .O_CTL(ctl),
    .O_KEY_ARMED(armed), .O_KEY_BLOCKED(blocked), .O_FLASH_ERROR_RESET(err_rst),
    .O_FLASH_ERROR_FLAG(err_flag), .O_EXTERNAL_DATA_RAM_WR(external_data_ram_wr), .O_EXTERNAL_DATA_RAM(external_data_ram_q), .O_CREAD_DATA(rdata));
  fpec_core_model fpec_core_model_inst (
    .i_clk(clk), .i_stall(stall), .o_ctl_wr(ctl_wr), .o_key_wr(key_wr),
    .o_xwr_valid(xwr_valid), .o_xwr(xwr));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (external_data_ram_wr === 1'b1) begin
      external_data_ram_hits++;
      external_data_ram_seen = external_data_ram_q;
    end
    if (err_rst === 1'b1) begin
      err_hits++;
    end
    // Stall length is counted at every edge, whoever started the operation
    if (stall === 1'b1) begin
      stall_cnt++;
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wait_stall(input int exp);
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 20000) begin
      tick(1);
      n++;
    end
    check("stall cycles", 16'(stall_cnt - stall_mark), 16'(exp));
    stall_mark = stall_cnt;
  endtask
  task automatic rd(input logic [15:0] a);
    cr_valid = 1'b1;
    cr_addr  = a;
    tick(1);
    cr_valid = 1'b0;
    tick(1);
  endtask
  task automatic sysr();
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    tick(1);
  endtask
  task automatic sw_op(input logic [15:0] a, input logic [7:0] d);
    fpec_core_model_inst.issue(2'd0, 16'h0000, 8'h01);
    fpec_core_model_inst.unlock();
    fpec_core_model_inst.issue(2'd2, a, d);
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(3);
    check("idle", {5'h00, stall, armed, blocked, ctl}, 16'h0000);
    // Erase before write, bits only cleared by a write
    foreach (rows[i]) begin
      fpec_core_model_inst.issue(2'd0, 16'h0000, rows[i].ctl);
      fpec_core_model_inst.unlock();
      check("armed", {15'h0000, armed}, 16'h0001);
      fpec_core_model_inst.issue(2'd2, rows[i].addr, rows[i].data);
      wait_stall(rows[i].ctl[1] ? ERASE_N : WRITE_N);
      check("relocked", {15'h0000, armed}, 16'h0000);
      check("ctl kept", {8'h00, ctl}, {8'h00, rows[i].ctl});
      rd(rows[i].raddr);
      check("mem", {8'h00, rdata}, {8'h00, rows[i].exp});
      $display("row %0d done", i);
    end
    check("no data ram", 16'(external_data_ram_hits), 16'h0000);
    fpec_core_model_inst.issue(2'd0, 16'h0000, 8'h00);
    fpec_core_model_inst.issue(2'd2, 16'h0007, 8'h3c);
    tick(2);
    check("data ram hits", 16'(external_data_ram_hits), 16'h0001);
    check("data ram addr", external_data_ram_seen.addr, 16'h0007);
    check("data ram data", {8'h00, external_data_ram_seen.data}, 16'h003c);
    $display("data ram test done");
    sw_op(16'h1e00, 8'h00);
    wait_stall(0);
    rd(16'h1e00);
    check("error pulses", 16'(err_hits), 16'h0002);
    sysr();
    check("error flag", {15'h0000, err_flag}, 16'h0001);
    $display("error reset test done");
    fpec_core_model_inst.issue(2'd1, 16'h0000, KEY_SECOND_CODE);
    check("blocked", {15'h0000, blocked}, 16'h0001);
    sw_op(16'h0007, 8'h00);
    wait_stall(0);
    sysr();
    check("unblocked", {15'h0000, blocked}, 16'h0000);
    fpec_core_model_inst.issue(2'd0, 16'h0000, 8'h01);
    fpec_core_model_inst.issue(2'd2, 16'h0007, 8'h00);
    check("blocked early", {15'h0000, blocked}, 16'h0001);
    fpec_core_model_inst.unlock();
    fpec_core_model_inst.issue(2'd2, 16'h0007, 8'h00);
    wait_stall(0);
    sysr();
    $display("key test done");
    blank = 1'b1;
    tick(3);
    sw_op(16'h0007, 8'h00);
    wait_stall(0);
    check("blank no block", {15'h0000, blocked}, 16'h0000);
    blank = 1'b0;
    tick(3);
    rd(16'h0007);
    check("mem kept", {8'h00, rdata}, 16'h00ff);
    dbg    = '{addr: 16'h0007, data: 8'h5a};
    dbg_wr = 1'b1;
    tick(1);
    dbg_wr = 1'b0;
    dbg    = ~dbg;
    wait_stall(WRITE_N);
    rd(16'h0007);
    check("debug write", {8'h00, rdata}, 16'h005a);
    dbg       = '{addr: 16'h0105, data: 8'h00};
    dbg_erase = 1'b1;
    tick(1);
    dbg_erase = 1'b0;
    dbg       = ~dbg;
    wait_stall(ERASE_N);
    rd(16'h0007);
    check("debug erase", {8'h00, rdata}, 16'h00ff);
    $display("blank and debug test done");
    end_sim();
  end
endmodule // flash_program_erase_control_test
`default_nettype wire
